// file: bench/rcr_reset_cause_tb.sv
// Self-checking bench for the reset-cause register block.
`timescale 1ns/1ps
`default_nettype none
`include "rcr_defs.svh"

`define CHK(got, exp, what) \
    begin \
        checked++; \
        if ((got) !== (exp)) \
        begin \
            $display("CHECK FAILED at %0t: %s", $time, what); \
            bad_count++; \
        end \
    end

module rcr_reset_cause_tb;
    import rcr_pkg::*;

    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    rcr_byte_type sfr_wdata = 8'h00;
    rcr_byte_type sfr_rdata;
    logic ext_reset_pin_n = 1'b1;
    logic comparator_out = 1'b1;
    logic supply_low = 1'b0;
    logic clock_stop_timeout = 1'b0;
    logic watchdog_overflow = 1'b0;
    logic flash_fault = 1'b0;
    logic stopped_clock_detector_en;
    logic system_reset;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    int held;
    rcr_byte_type rd_val;

    rcr_reset_cause DUT
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .clk_en(clk_en),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata),
        .ext_reset_pin_n(ext_reset_pin_n),
        .comparator_out(comparator_out),
        .supply_low(supply_low),
        .clock_stop_timeout(clock_stop_timeout),
        .watchdog_overflow(watchdog_overflow),
        .flash_fault(flash_fault),
        .stopped_clock_detector_en(stopped_clock_detector_en),
        .system_reset(system_reset)
    );

    always #25 clk_sys = ~clk_sys;

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    // The run needs well under a thousand cycles; this ends a hang.
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    // Always a plain write of the whole byte, never read-modify-write.
    task automatic reg_write(input logic [7:0] addr, input rcr_byte_type d);
        @(negedge clk_sys);
        sfr_addr = addr;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] addr, output rcr_byte_type d);
        @(negedge clk_sys);
        sfr_addr = addr;
        sfr_rd = 1'b1;
        @(negedge clk_sys);
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask : reg_read

    task automatic wait_release(output int n);
        n = 0;
        while (system_reset !== 1'b0 && n < 200)
        begin
            @(negedge clk_sys);
            n++;
        end
        `CHK(system_reset, 1'b0, "reset never released")
    endtask : wait_release

    task automatic expect_reset(output int n);
        int k;
        k = 0;
        while (system_reset !== 1'b1 && k < 8)
        begin
            @(negedge clk_sys);
            k++;
        end
        `CHK(system_reset, 1'b1, "no system reset")
        wait_release(n);
    endtask : expect_reset

    task automatic check_cause(input rcr_byte_type exp);
        reg_read(`RCR_ADDR, rd_val);
        `CHK(rd_val, exp, "cause byte")
    endtask : check_cause

    task automatic quiet(input int n);
        repeat (n) @(negedge clk_sys);
        `CHK(system_reset, 1'b0, "unexpected system reset")
    endtask : quiet

    initial
    begin
        repeat (3) @(negedge clk_sys);
        reset = 1'b0;
        wait_release(held);
        check_cause(8'h02);
        reg_read(8'hee, rd_val);
        `CHK(rd_val, 8'h00, "unmapped read")
        $display("test power_on done");

        // Bit 7 set as well: it must be dropped, bit 4 still forces.
        reg_write(`RCR_ADDR, 8'h90);
        expect_reset(held);
        `CHK(held, 20, "reset hold length")
        check_cause(8'h10);
        clk_en = 1'b0;
        reg_write(`RCR_ADDR, 8'h10);
        clk_en = 1'b1;
        quiet(4);
        $display("test software done");

        @(negedge clk_sys);
        watchdog_overflow = 1'b1;
        @(negedge clk_sys);
        watchdog_overflow = 1'b0;
        expect_reset(held);
        check_cause(8'h08);
        @(negedge clk_sys);
        flash_fault = 1'b1;
        @(negedge clk_sys);
        flash_fault = 1'b0;
        expect_reset(held);
        check_cause(8'h40);
        $display("test watchdog_flash done");

        // Pin held past the hold count keeps the system in reset.
        ext_reset_pin_n = 1'b0;
        repeat (30) @(negedge clk_sys);
        `CHK(system_reset, 1'b1, "pin reset held")
        ext_reset_pin_n = 1'b1;
        wait_release(held);
        check_cause(8'h01);
        $display("test pin done");

        comparator_out = 1'b0;
        quiet(6);
        reg_write(`RCR_ADDR, 8'h20);
        expect_reset(held);
        comparator_out = 1'b1;
        check_cause(8'h20);
        $display("test comparator done");

        reg_write(`RCR_ADDR, 8'h04);
        `CHK(stopped_clock_detector_en, 1'b1, "detector on")
        reg_write(`RCR_ADDR, 8'h00);
        `CHK(stopped_clock_detector_en, 1'b0, "detector off")
        clock_stop_timeout = 1'b1;
        quiet(6);
        reg_write(`RCR_ADDR, 8'h04);
        expect_reset(held);
        clock_stop_timeout = 1'b0;
        check_cause(8'h04);
        $display("test stopped_clock done");

        supply_low = 1'b1;
        quiet(6);
        // The low indication is a real supply fault here, not turn-on chatter.
        reg_write(`RCR_ADDR, 8'h02);
        supply_low = 1'b0;
        expect_reset(held);
        check_cause(8'h02);
        $display("test supply done");

        // A second power-on reset in mid-run must restore every default,
        // including the supply arm that this write clears.
        reg_write(`RCR_ADDR, 8'h04);
        `CHK(stopped_clock_detector_en, 1'b1, "detector armed")
        reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        `CHK(stopped_clock_detector_en, 1'b0, "arm kept over reset")
        `CHK(system_reset, 1'b1, "no reset during power-on")
        reset = 1'b0;
        wait_release(held);
        `CHK(held, 20, "power-on hold length")
        check_cause(8'h02);
        // One enabled edge is enough for the synchroniser to capture it.
        supply_low = 1'b1;
        @(negedge clk_sys);
        supply_low = 1'b0;
        expect_reset(held);
        check_cause(8'h02);
        $display("test second_power_on done");
        give_verdict();
    end
endmodule : rcr_reset_cause_tb

`default_nettype wire

// file: hw/rcr_defs.svh
// Register address, field positions, reset values and timing counts.
`ifndef RCR_DEFS_SVH
`define RCR_DEFS_SVH

`define RCR_ADDR 8'hef
`define RCR_BIT_RESERVED 7
`define RCR_BIT_FLASH 6
`define RCR_BIT_COMP 5
`define RCR_BIT_SOFT 4
`define RCR_BIT_WDOG 3
`define RCR_BIT_STOP 2
`define RCR_BIT_SUPPLY 1
`define RCR_BIT_PIN 0
`define RCR_CAUSE_RESET 8'h02
`define RCR_SUPPLY_EN_RESET 1'b1
`define RCR_SYNC_IDLE 4'hc
`define RCR_CLK_PERIOD_NS 50
`define RCR_HOLD_NS 1000
`define RCR_HOLD_CYCLES ((`RCR_HOLD_NS + `RCR_CLK_PERIOD_NS - 1) / `RCR_CLK_PERIOD_NS)
`define RCR_COUNT_W 5

`endif

// file: hw/rcr_pkg.sv
// Types shared by the reset-cause register block.
package rcr_pkg;

    typedef logic [7:0] rcr_byte_type;

    typedef enum logic
    {
        RCR_RUN,
        RCR_HOLD
    } rcr_state_type;

endpackage : rcr_pkg

// file: hw/rcr_reset_cause.sv
// Reset-cause and reset-source control register with reset sequencing.
//
// Function
// - The register answers at address 0xef whatever register page is active.
// - Bit 6 is read-only and reads one after a flash access fault reset.
// - Writing one to bit 5 arms the comparator as an active-low reset source.
// - Bit 5 reads one only when the comparator caused the latest reset.
// - Writing one to bit 4 forces an immediate system reset.
// - Bit 4 reads one after a software-forced reset.
// - Bit 3 is read-only and reads one after a watchdog overflow reset.
// - Writing one to bit 2 lets the stopped-clock detector reset the system.
// - Bit 2 reads one when the stopped-clock detector caused the reset.
// - Writing one to bit 1 makes a low supply indication reset the device.
// - Bit 1 is set by every power-on or supply reset, others then read zero.
// - Bit 0 is read-only and reads one after an external pin reset.
// - Writing zero to bit 2 switches the stopped-clock detector off.
`timescale 1ns/1ps
`default_nettype none
`include "rcr_defs.svh"

module rcr_reset_cause
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire rcr_pkg::rcr_byte_type sfr_wdata,
    output rcr_pkg::rcr_byte_type sfr_rdata,
    input wire logic ext_reset_pin_n,
    input wire logic comparator_out,
    input wire logic supply_low,
    input wire logic clock_stop_timeout,
    input wire logic watchdog_overflow,
    input wire logic flash_fault,
    output logic stopped_clock_detector_en,
    output logic system_reset
);
    import rcr_pkg::*;

    localparam logic [`RCR_COUNT_W-1:0] HOLD_LAST =
        `RCR_COUNT_W'(`RCR_HOLD_CYCLES - 1);

    function automatic logic reg_hit(input logic [7:0] addr);
        reg_hit = (addr == `RCR_ADDR);
    endfunction : reg_hit

    logic [3:0] sync_bus;
    logic pin_n_s;
    logic comp_s;
    logic supply_low_s;
    logic stop_timeout_s;

    // Asynchronous sources are synchronised; the watchdog and flash fault
    // come from logic on this clock and are used directly.
    rcr_sync
    #(
        .WIDTH(4),
        .IDLE(`RCR_SYNC_IDLE)
    )
    u_sync
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .clk_en(clk_en),
        .async_in({ext_reset_pin_n, comparator_out, supply_low,
            clock_stop_timeout}),
        .sync_out(sync_bus)
    );

    assign pin_n_s = sync_bus[3];
    assign comp_s = sync_bus[2];
    assign supply_low_s = sync_bus[1];
    assign stop_timeout_s = sync_bus[0];

    rcr_state_type state;
    rcr_state_type next_state;
    logic [`RCR_COUNT_W-1:0] count;
    logic [`RCR_COUNT_W-1:0] next_count;
    rcr_byte_type cause;
    rcr_byte_type next_cause;
    rcr_byte_type req_vec;
    logic comp_en;
    logic next_comp_en;
    logic stop_en;
    logic next_stop_en;
    logic supply_en;
    logic next_supply_en;
    logic wr_hit;
    logic rd_hit;

    assign wr_hit = sfr_wr && reg_hit(sfr_addr);
    assign rd_hit = sfr_rd && reg_hit(sfr_addr);

    // One source wins when several fire at once, so exactly one flag is
    // recorded. The supply source ranks first since it may undo the rest.
    always_comb
    begin
        req_vec = 8'h00;
        if (supply_en && supply_low_s)
            req_vec[`RCR_BIT_SUPPLY] = 1'b1;
        else if (!pin_n_s)
            req_vec[`RCR_BIT_PIN] = 1'b1;
        else if (stop_en && stop_timeout_s)
            req_vec[`RCR_BIT_STOP] = 1'b1;
        else if (comp_en && !comp_s)
            req_vec[`RCR_BIT_COMP] = 1'b1;
        else if (watchdog_overflow)
            req_vec[`RCR_BIT_WDOG] = 1'b1;
        else if (flash_fault)
            req_vec[`RCR_BIT_FLASH] = 1'b1;
        else if (wr_hit && sfr_wdata[`RCR_BIT_SOFT])
            req_vec[`RCR_BIT_SOFT] = 1'b1;
    end

    always_comb
    begin
        next_state = state;
        next_count = count;
        next_cause = cause;
        next_comp_en = comp_en;
        next_stop_en = stop_en;
        next_supply_en = supply_en;
        if (clk_en)
        begin
            unique case (state)
                RCR_RUN:
                begin
                    if (req_vec != 8'h00)
                    begin
                        // Only the firing source keeps its flag.
                        next_cause = req_vec;
                        next_state = RCR_HOLD;
                        next_count = HOLD_LAST;
                        // A system reset disarms the comparator and the
                        // stopped-clock detector; the supply arm survives.
                        next_comp_en = 1'b0;
                        next_stop_en = 1'b0;
                    end
                    else if (wr_hit)
                    begin
                        // Reserved bit 7 and read-only bits are dropped.
                        next_comp_en = sfr_wdata[`RCR_BIT_COMP];
                        next_stop_en = sfr_wdata[`RCR_BIT_STOP];
                        next_supply_en = sfr_wdata[`RCR_BIT_SUPPLY];
                    end
                end
                RCR_HOLD:
                begin
                    // The pin keeps the system in reset for as long as it
                    // is held low, on top of the minimum hold time.
                    if (count != '0)
                        next_count = count - `RCR_COUNT_W'(1);
                    else if (pin_n_s)
                        next_state = RCR_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state <= RCR_HOLD;
            count <= HOLD_LAST;
            cause <= `RCR_CAUSE_RESET;
            comp_en <= 1'b0;
            stop_en <= 1'b0;
            supply_en <= `RCR_SUPPLY_EN_RESET;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            cause <= next_cause;
            comp_en <= next_comp_en;
            stop_en <= next_stop_en;
            supply_en <= next_supply_en;
        end
    end

    assign system_reset = (state == RCR_HOLD);
    assign stopped_clock_detector_en = stop_en;

    rcr_byte_type next_rdata;

    // Reads return cause flags, not the arm bits, which is why software
    // must never update this register by read-modify-write.
    always_comb
    begin
        next_rdata = sfr_rdata;
        if (clk_en)
        begin
            next_rdata = 8'h00;
            if (rd_hit)
            begin
                next_rdata = cause;
                next_rdata[`RCR_BIT_RESERVED] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            sfr_rdata <= 8'h00;
        else
            sfr_rdata <= next_rdata;
    end

    sequence soft_write_s;
        clk_en && state == RCR_RUN && wr_hit && sfr_wdata[`RCR_BIT_SOFT]
            && pin_n_s && !(supply_en && supply_low_s)
            && !(stop_en && stop_timeout_s) && !(comp_en && !comp_s)
            && !watchdog_overflow && !flash_fault;
    endsequence

    sequence hold_entered_s;
        system_reset && count == HOLD_LAST;
    endsequence

    addr_read_a: assert property (@(posedge clk_sys) disable iff (reset)
        clk_en && rd_hit |=> sfr_rdata == {1'b0, $past(cause[6:0])})
        else $error("register read returned wrong data");

    reserved_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
        sfr_rdata[7] == 1'b0)
        else $error("reserved bit read as one");

    soft_force_a: assert property (@(posedge clk_sys) disable iff (reset)
        soft_write_s |=> hold_entered_s)
        else $error("software write did not force a reset");

    soft_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
        soft_write_s |=> cause == 8'h10)
        else $error("software reset flag not recorded alone");

    comp_reset_a: assert property (@(posedge clk_sys) disable iff (reset)
        clk_en && state == RCR_RUN && comp_en && !comp_s && pin_n_s
            && !(supply_en && supply_low_s) && !(stop_en && stop_timeout_s)
            |=> system_reset && cause == 8'h20)
        else $error("armed comparator low did not reset");

    comp_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(cause[`RCR_BIT_COMP]) |-> $past(comp_en) && !$past(comp_s))
        else $error("comparator flag set without its cause");

    wdog_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(cause[`RCR_BIT_WDOG]) |-> $past(watchdog_overflow))
        else $error("watchdog flag set without overflow");

    flash_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(cause[`RCR_BIT_FLASH]) |-> $past(flash_fault))
        else $error("flash flag set without fault");

    stop_off_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(cause[`RCR_BIT_STOP]) |-> $past(stop_en))
        else $error("disabled detector caused a reset");

    stop_reset_a: assert property (@(posedge clk_sys) disable iff (reset)
        clk_en && state == RCR_RUN && stop_en && stop_timeout_s && pin_n_s
            && !(supply_en && supply_low_s) |=> cause == 8'h04)
        else $error("stopped clock did not reset");

    supply_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
        clk_en && state == RCR_RUN && supply_en && supply_low_s
            |=> hold_entered_s ##0 cause == 8'h02)
        else $error("supply reset did not set its flag");

    pin_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(cause[`RCR_BIT_PIN]) |-> !$past(pin_n_s))
        else $error("pin flag set without pin reset");

    cause_onehot_a: assert property (@(posedge clk_sys) disable iff (reset)
        $onehot(cause))
        else $error("cause flags not one-hot");

    hold_time_a: assert property (@(posedge clk_sys) disable iff (reset)
        hold_entered_s ##1 clk_en[*1] |-> system_reset)
        else $error("reset released too early");

endmodule : rcr_reset_cause

`default_nettype wire

// file: hw/rcr_sync.sv
// Two-stage synchroniser for asynchronous level inputs.
`timescale 1ns/1ps
`default_nettype none

module rcr_sync
#(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] IDLE = '0
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    // The first stage feeds only the second stage.
    always_comb
    begin
        next_stage1 = clk_en ? async_in : stage1;
        next_sync_out = clk_en ? stage1 : sync_out;
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            stage1 <= IDLE;
            sync_out <= IDLE;
        end
        else
        begin
            stage1 <= next_stage1;
            sync_out <= next_sync_out;
        end
    end

endmodule : rcr_sync

`default_nettype wire
